// file: ddc_map.vh
/*
 * register offsets, field positions, reset values and derived ratios for the
 * digital downconversion and decimation path.
 * assumes: included by the design files of that path, by bare name.
 */
// Function
// - 5-bit real in, complex dc samples out
// - coarse mixer on input, fine after stage one
// - coarse 6-bit tuning, fine 8-bit tuning
// - composite step fadc/3072 or fadc/4096
// - select 1..4 gives 32, 24, 16, 12
// - device computes both tuning words at init
// - calculation uses clock rate and if setting
// - coarse word is round(64*fif/fadc)
// - fine word is round(m*residual), two's complement
// - coarse phase init, lsb 1/64 cycle
// - fine phase init, lsb 1/1024 cycle
// - stage one decimates 3 or 4
// - stages two, three each decimate two
// - stage four only for 24 and 32
// - identical symmetric fir chains for i, q
// - every filter mode has linear phase
// - latency about 34.2 or 32.3 outputs
// - converter to output delay fixed, deterministic
`ifndef DDC_MAP_VH
`define DDC_MAP_VH
`define DDC_ADDR_FADC0 10'h100
`define DDC_ADDR_FADC1 10'h101
`define DDC_ADDR_FIF0 10'h102
`define DDC_ADDR_FIF1 10'h103
`define DDC_ADDR_DEC_SEL 10'h140
`define DDC_ADDR_COARSE_WORD 10'h141
`define DDC_ADDR_FINE_WORD 10'h142
`define DDC_ADDR_COARSE_INIT 10'h143
`define DDC_ADDR_FINE_INIT0 10'h144
`define DDC_ADDR_FINE_INIT1 10'h145
`define DDC_ADDR_STATUS 10'h146
`define DDC_DEC_SEL_LSB 0
`define DDC_DEC_SEL_MSB 2
`define DDC_DEC_SEL_RST 8'h04
`define DDC_FADC_RST 16'h0c80
`define DDC_FIF_RST 16'h00c8
`define DDC_SEL_D32 3'h1
`define DDC_SEL_D24 3'h2
`define DDC_SEL_D16 3'h3
`define DDC_SEL_D12 3'h4
`define DDC_COARSE_SCALE 64
`define DDC_M3 3072
`define DDC_M4 4096
`define DDC_DIV_BITS 32
`endif

// file: ddc_fir_dec2.v
/*
 * one symmetric fir decimate-by-2 stage, with an optional bypass.
 * assumes: in_vld is a one-cycle pulse per input sample on ref_clk.
 */
`timescale 1ns/1ps
module ddc_fir_dec2 #(
    parameter W = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire bypass,
    input wire in_vld,
    input wire signed [W-1:0] in_i,
    input wire signed [W-1:0] in_q,
    output reg out_vld,
    output reg signed [W-1:0] out_i,
    output reg signed [W-1:0] out_q
);
    // taps 1 3 3 1 over 8: symmetric, so the phase is linear
    reg signed [W-1:0] di_q [0:2];
    reg signed [W-1:0] dq_q [0:2];
    reg phase_q;
    wire signed [W+2:0] si = in_i + di_q[2] + 3'sh3 * (di_q[0] + di_q[1]);
    wire signed [W+2:0] sq = in_q + dq_q[2] + 3'sh3 * (dq_q[0] + dq_q[1]);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            di_q[0] <= {W{1'b0}};
            di_q[1] <= {W{1'b0}};
            di_q[2] <= {W{1'b0}};
            dq_q[0] <= {W{1'b0}};
            dq_q[1] <= {W{1'b0}};
            dq_q[2] <= {W{1'b0}};
            phase_q <= 1'b0;
            out_vld <= 1'b0;
            out_i <= {W{1'b0}};
            out_q <= {W{1'b0}};
        end else if (clk_en) begin
            out_vld <= 1'b0;
            if (in_vld) begin
                di_q[0] <= in_i;
                di_q[1] <= di_q[0];
                di_q[2] <= di_q[1];
                dq_q[0] <= in_q;
                dq_q[1] <= dq_q[0];
                dq_q[2] <= dq_q[1];
                phase_q <= ~phase_q;
                if (bypass) begin
                    out_vld <= 1'b1;
                    out_i <= in_i;
                    out_q <= in_q;
                end else if (phase_q) begin
                    out_vld <= 1'b1;
                    out_i <= si[W+2:3];
                    out_q <= sq[W+2:3];
                end
            end
        end
    end
endmodule // ddc_fir_dec2

// file: ddc_nco_decimator.v
/*
 * receive path: coarse mixer, decimate 3/4 stage, fine mixer, then
 * two or three decimate-by-2 stages giving complex zero-if samples.
 * assumes: adc_data and sysref are asynchronous pins; registers reached over
 * a simple strobed address/data port on ref_clk.
 */
`timescale 1ns/1ps
`include "ddc_map.vh"
module ddc_nco_decimator #(
    parameter OW = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] adc_data,
    input wire sysref,
    input wire reg_wr,
    input wire reg_rd,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg init_done,
    output reg iq_vld,
    output reg signed [OW-1:0] iq_i,
    output reg signed [OW-1:0] iq_q
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [15:0] fadc_q;
    reg [15:0] fif_q;
    reg [7:0] dec_sel_q;
    reg [5:0] coarse_freq_word_q;
    reg [7:0] fine_freq_word_q;
    reg [5:0] coarse_phase_init_q;
    reg [9:0] fine_phase_init_q;
    reg recalc_q;
    wire [2:0] decimation_select = dec_sel_q[`DDC_DEC_SEL_MSB:`DDC_DEC_SEL_LSB];
    wire div3 = (decimation_select == `DDC_SEL_D24) || (decimation_select == `DDC_SEL_D12);
    wire use_stage4 = (decimation_select == `DDC_SEL_D32) || (decimation_select == `DDC_SEL_D24);
    // other select values fall through to the decimate-by-16 shape
    wire calc_start;
    wire calc_busy;
    wire calc_done;
    wire [5:0] calc_coarse;
    wire [7:0] calc_fine;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fadc_q <= `DDC_FADC_RST;
            fif_q <= `DDC_FIF_RST;
            dec_sel_q <= `DDC_DEC_SEL_RST;
            coarse_freq_word_q <= 6'h00;
            fine_freq_word_q <= 8'h00;
            coarse_phase_init_q <= 6'h00;
            fine_phase_init_q <= 10'h000;
            recalc_q <= 1'b1;
            init_done <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            // a retrigger that lands mid-calculation stays pending
            if (calc_start) recalc_q <= 1'b0;
            if (calc_done) begin
                coarse_freq_word_q <= calc_coarse;
                fine_freq_word_q <= calc_fine;
                init_done <= ~recalc_q;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `DDC_ADDR_FADC0: fadc_q[7:0] <= reg_wdata;
                    `DDC_ADDR_FADC1: fadc_q[15:8] <= reg_wdata;
                    `DDC_ADDR_FIF0: fif_q[7:0] <= reg_wdata;
                    `DDC_ADDR_FIF1: begin
                        fif_q[15:8] <= reg_wdata;
                        recalc_q <= 1'b1;
                        init_done <= 1'b0;
                    end
                    `DDC_ADDR_DEC_SEL: begin
                        dec_sel_q <= reg_wdata;
                        recalc_q <= 1'b1;
                        init_done <= 1'b0;
                    end
                    `DDC_ADDR_COARSE_WORD: coarse_freq_word_q <= reg_wdata[5:0];
                    `DDC_ADDR_FINE_WORD: fine_freq_word_q <= reg_wdata;
                    `DDC_ADDR_COARSE_INIT: coarse_phase_init_q <= reg_wdata[5:0];
                    `DDC_ADDR_FINE_INIT0: fine_phase_init_q[7:0] <= reg_wdata;
                    `DDC_ADDR_FINE_INIT1: fine_phase_init_q[9:8] <= reg_wdata[1:0];
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `DDC_ADDR_FADC0: reg_rdata <= fadc_q[7:0];
                    `DDC_ADDR_FADC1: reg_rdata <= fadc_q[15:8];
                    `DDC_ADDR_FIF0: reg_rdata <= fif_q[7:0];
                    `DDC_ADDR_FIF1: reg_rdata <= fif_q[15:8];
                    `DDC_ADDR_DEC_SEL: reg_rdata <= dec_sel_q;
                    `DDC_ADDR_COARSE_WORD: reg_rdata <= {2'b00, coarse_freq_word_q};
                    `DDC_ADDR_FINE_WORD: reg_rdata <= fine_freq_word_q;
                    `DDC_ADDR_COARSE_INIT: reg_rdata <= {2'b00, coarse_phase_init_q};
                    `DDC_ADDR_FINE_INIT0: reg_rdata <= fine_phase_init_q[7:0];
                    `DDC_ADDR_FINE_INIT1: reg_rdata <= {6'h00, fine_phase_init_q[9:8]};
                    `DDC_ADDR_STATUS: reg_rdata <= {6'h00, calc_busy, init_done};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // tuning word calculation: serial restoring divider
    // ------------------------------------------------------------------
    // x = fif * M / fadc with M = 3072 or 4096, rounded; coarse = round(x*64/M),
    // fine = x - coarse*M/64, which equals round(M*(fif/fadc - coarse/64))
    localparam C_IDLE = 2'd0;
    localparam C_DIV = 2'd1;
    localparam C_FIN = 2'd2;
    reg [1:0] c_state_q;
    reg [5:0] c_cnt_q;
    reg [31:0] c_num_q;
    reg [31:0] c_rem_q;
    reg [31:0] c_quo_q;
    reg c_done_q;
    wire [31:0] m_val = div3 ? `DDC_M3 : `DDC_M4;
    wire [31:0] rem_sh = {c_rem_q[30:0], c_num_q[31]};
    wire rem_ge = rem_sh >= {16'h0000, fadc_q};
    // quotient carries one extra fraction bit for rounding
    wire [31:0] x_round = (c_quo_q + 32'd1) >> 1;
    wire [31:0] step = div3 ? 32'd48 : 32'd64;
    wire [31:0] coarse_full = (x_round + (step >> 1)) / step;
    wire [31:0] fine_full = x_round - coarse_full * step;
    assign calc_start = (c_state_q == C_IDLE) && recalc_q;
    assign calc_busy = (c_state_q != C_IDLE);
    assign calc_done = c_done_q;
    assign calc_coarse = coarse_full[5:0];
    assign calc_fine = fine_full[7:0];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_state_q <= C_IDLE;
            c_cnt_q <= 6'd0;
            c_num_q <= 32'd0;
            c_rem_q <= 32'd0;
            c_quo_q <= 32'd0;
            c_done_q <= 1'b0;
        end else if (clk_en) begin
            c_done_q <= 1'b0;
            case (c_state_q)
                C_IDLE: begin
                    if (recalc_q) begin
                        c_num_q <= fif_q * m_val * 32'd2;
                        c_rem_q <= 32'd0;
                        c_quo_q <= 32'd0;
                        c_cnt_q <= 6'd0;
                        c_state_q <= C_DIV;
                    end
                end
                C_DIV: begin
                    c_num_q <= {c_num_q[30:0], 1'b0};
                    c_rem_q <= rem_ge ? rem_sh - {16'h0000, fadc_q} : rem_sh;
                    c_quo_q <= {c_quo_q[30:0], rem_ge};
                    c_cnt_q <= c_cnt_q + 6'd1;
                    if (c_cnt_q == 6'd31) begin
                        c_state_q <= C_FIN;
                    end
                end
                C_FIN: begin
                    c_done_q <= 1'b1;
                    c_state_q <= C_IDLE;
                end
                default: c_state_q <= C_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    reg [4:0] adc_s1_q, adc_s2_q, adc_s3_q, adc_q;
    reg sr_s1_q, sr_s2_q, sr_s3_q, sr_q, sr_d1_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_s1_q <= 5'h00;
            adc_s2_q <= 5'h00;
            adc_s3_q <= 5'h00;
            adc_q <= 5'h00;
            sr_s1_q <= 1'b0;
            sr_s2_q <= 1'b0;
            sr_s3_q <= 1'b0;
            sr_q <= 1'b0;
            sr_d1_q <= 1'b0;
        end else if (clk_en) begin
            adc_s1_q <= adc_data;
            adc_s2_q <= adc_s1_q;
            adc_s3_q <= adc_s2_q;
            if (adc_s2_q == adc_s3_q) adc_q <= adc_s3_q;
            sr_s1_q <= sysref;
            sr_s2_q <= sr_s1_q;
            sr_s3_q <= sr_s2_q;
            if (sr_s2_q == sr_s3_q) sr_q <= sr_s3_q;
            sr_d1_q <= sr_q;
        end
    end
    wire sysref_evt = sr_q & ~sr_d1_q;

    // ------------------------------------------------------------------
    // coarse mixer and decimate-by-3/4 stage
    // ------------------------------------------------------------------
    function signed [OW-1:0] mix;
        input signed [OW-1:0] x;
        input [1:0] quad;
        input cosine;
        reg [1:0] q;
        begin
            // quarter-wave oscillator: values +1 0 -1 0 per quadrant
            q = cosine ? quad : quad - 2'd1;
            case (q)
                2'd0: mix = x;
                2'd2: mix = -x;
                default: mix = {OW{1'b0}};
            endcase
        end
    endfunction

    reg [5:0] coarse_acc_q;
    reg [9:0] fine_acc_q;
    reg [1:0] d1_cnt_q;
    reg signed [OW-1:0] s1_i_q, s1_q_q;
    reg s1_vld_q;
    // signed 5-bit converter code, centred on zero
    wire signed [OW-1:0] adc_x = {{(OW-5){~adc_q[4]}}, ~adc_q[4], adc_q[3:0]} <<< 6;
    wire signed [OW-1:0] c_i = mix(adc_x, coarse_acc_q[5:4], 1'b1);
    wire signed [OW-1:0] c_q = -mix(adc_x, coarse_acc_q[5:4], 1'b0);
    wire [1:0] d1_last = div3 ? 2'd2 : 2'd3;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coarse_acc_q <= 6'h00;
            d1_cnt_q <= 2'd0;
            s1_i_q <= {OW{1'b0}};
            s1_q_q <= {OW{1'b0}};
            s1_vld_q <= 1'b0;
        end else if (clk_en) begin
            s1_vld_q <= 1'b0;
            if (sysref_evt) begin
                coarse_acc_q <= coarse_phase_init_q;
                d1_cnt_q <= 2'd0;
                s1_i_q <= {OW{1'b0}};
                s1_q_q <= {OW{1'b0}};
            end else begin
                coarse_acc_q <= coarse_acc_q + coarse_freq_word_q;
                // boxcar over 3 or 4 samples, symmetric so phase stays linear
                if (d1_cnt_q == d1_last) begin
                    d1_cnt_q <= 2'd0;
                    s1_vld_q <= 1'b1;
                    s1_i_q <= s1_i_q + (c_i >>> 2);
                    s1_q_q <= s1_q_q + (c_q >>> 2);
                end else begin
                    // the first sample of a group restarts the sum
                    d1_cnt_q <= d1_cnt_q + 2'd1;
                    s1_i_q <= (d1_cnt_q == 2'd0) ? (c_i >>> 2) : s1_i_q + (c_i >>> 2);
                    s1_q_q <= (d1_cnt_q == 2'd0) ? (c_q >>> 2) : s1_q_q + (c_q >>> 2);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // fine mixer: rotation by the top two phase bits
    // ------------------------------------------------------------------
    reg signed [OW-1:0] f_i_q, f_q_q;
    reg f_vld_q;
    wire [9:0] fine_step = {{2{fine_freq_word_q[7]}}, fine_freq_word_q};
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_acc_q <= 10'h000;
            f_i_q <= {OW{1'b0}};
            f_q_q <= {OW{1'b0}};
            f_vld_q <= 1'b0;
        end else if (clk_en) begin
            f_vld_q <= s1_vld_q;
            if (sysref_evt) begin
                fine_acc_q <= fine_phase_init_q;
            end else if (s1_vld_q) begin
                fine_acc_q <= fine_acc_q + fine_step;
                case (fine_acc_q[9:8])
                    2'd0: begin f_i_q <= s1_i_q; f_q_q <= s1_q_q; end
                    2'd1: begin f_i_q <= s1_q_q; f_q_q <= -s1_i_q; end
                    2'd2: begin f_i_q <= -s1_i_q; f_q_q <= -s1_q_q; end
                    default: begin f_i_q <= -s1_q_q; f_q_q <= s1_i_q; end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // decimate-by-2 cascade, i and q carried together
    // ------------------------------------------------------------------
    wire [3:0] st_vld;
    wire signed [OW-1:0] st_i [0:3];
    wire signed [OW-1:0] st_q [0:3];
    assign st_vld[0] = f_vld_q;
    assign st_i[0] = f_i_q;
    assign st_q[0] = f_q_q;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_dec2
            ddc_fir_dec2 #(.W(OW)) u_dec2 (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .bypass((g == 2) ? ~use_stage4 : 1'b0),
                .in_vld(st_vld[g]),
                .in_i(st_i[g]),
                .in_q(st_q[g]),
                .out_vld(st_vld[g+1]),
                .out_i(st_i[g+1]),
                .out_q(st_q[g+1])
            );
        end
    endgenerate

    // fixed pipeline from converter to output, no data-dependent wait
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            iq_vld <= 1'b0;
            iq_i <= {OW{1'b0}};
            iq_q <= {OW{1'b0}};
        end else if (clk_en) begin
            iq_vld <= st_vld[3];
            if (st_vld[3]) begin
                iq_i <= st_i[3];
                iq_q <= st_q[3];
            end
        end
    end
endmodule // ddc_nco_decimator

// file: ddc_nco_decimator_assertions.sv
/* checker for the receive path, watching only the top ports.
   assumes: bound onto ddc_nco_decimator; one clock, async low reset. */
`timescale 1ns/1ps
module ddc_nco_decimator_checker #(
    parameter OW = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] adc_data,
    input wire sysref,
    input wire reg_wr,
    input wire reg_rd,
    input wire [9:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire init_done,
    input wire iq_vld,
    input wire signed [OW-1:0] iq_i,
    input wire signed [OW-1:0] iq_q
);
    // ----
    // shadow state
    // ----
    reg [2:0] sel_q;
    reg sys_q;
    reg [2:0] npulse_q;
    reg [7:0] gap_q;
    wire wr_en = reg_wr && clk_en;
    wire rd_en = reg_rd && clk_en;
    wire trig = wr_en && (reg_addr == 10'h103 || reg_addr == 10'h140);
    wire [7:0] factor = sel_q == 3'h1 ? 8'h20 : sel_q == 3'h2 ? 8'h18 : sel_q == 3'h3 ? 8'h10 : 8'h0c;
    // settled once four pulses passed with no mode write or sysref change
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 3'h4;
            sys_q <= 1'b0;
            npulse_q <= 3'h0;
            gap_q <= 8'h01;
        end else begin
            sys_q <= sysref;
            if (wr_en && reg_addr == 10'h140)
                sel_q <= reg_wdata[2:0];
            if ((wr_en && reg_addr == 10'h140) || sysref != sys_q)
                npulse_q <= 3'h0;
            else if (iq_vld && clk_en && npulse_q != 3'h4)
                npulse_q <= npulse_q + 3'h1;
            if (clk_en)
                gap_q <= iq_vld ? 8'h01 : gap_q + 8'h01;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    vld_pulse_a: assert property (iq_vld && clk_en |=> !iq_vld) else $error("iq_vld too long");
    sample_hold_a: assert property (!iq_vld |-> $stable(iq_i) && $stable(iq_q)) else $error("iq moved");
    out_gap_a: assert property (iq_vld && clk_en && npulse_q == 3'h4 |-> gap_q == factor)
        else $error("output spacing wrong");
    freeze_hold_a: assert property (!clk_en |=> $stable(iq_vld) && $stable(iq_i) && $stable(init_done))
        else $error("state moved while frozen");
    rdata_hold_a: assert property (!rd_en |=> $stable(reg_rdata)) else $error("rdata moved");
    unmapped_read_a: assert property (rd_en && (reg_addr < 10'h100 || reg_addr > 10'h146) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    sel_read_a: assert property (rd_en && reg_addr == 10'h140 |=> reg_rdata[2:0] == $past(sel_q))
        else $error("select readback wrong");
    calc_clear_a: assert property (trig |=> !init_done) else $error("init_done not cleared");
    calc_done_a: assert property (trig |-> ##[2:100] init_done) else $error("tuning calc late");
    cover property (iq_vld && clk_en && npulse_q == 3'h4 && sel_q == 3'h1);
    cover property (trig ##[2:100] init_done);
    cover property (!clk_en ##1 clk_en);
    cover property (rd_en && reg_addr > 10'h146);
endmodule // ddc_nco_decimator_checker

bind ddc_nco_decimator ddc_nco_decimator_checker #(.OW(OW)) ddc_nco_decimator_checker_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .clk_en(clk_en), .adc_data(adc_data), .sysref(sysref), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .init_done(init_done),
    .iq_vld(iq_vld), .iq_i(iq_i), .iq_q(iq_q));

// file: iq_link_sink.sv
/* model of the link transmitter that takes the complex samples.
   assumes: same clock and enable as the receive path. */
`timescale 1ns/1ps
module iq_link_sink #(
    parameter OW = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire iq_vld,
    input wire signed [OW-1:0] iq_i,
    input wire signed [OW-1:0] iq_q,
    output reg smp_vld,
    output reg signed [OW-1:0] smp_i,
    output reg signed [OW-1:0] smp_q,
    output reg [31:0] smp_count
);
    // i and q are taken together as one unit
    // samples are kept as sent: any residual tuning offset is the host's to remove
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_vld <= 1'b0;
            smp_i <= {OW{1'b0}};
            smp_q <= {OW{1'b0}};
            smp_count <= 32'h0;
        end else begin
            smp_vld <= iq_vld && clk_en;
            if (iq_vld && clk_en) begin
                smp_i <= iq_i;
                smp_q <= iq_q;
                smp_count <= smp_count + 32'h1;
            end
        end
    end
endmodule // iq_link_sink

// file: ddc_nco_decimator_bench.sv
/* self-checking bench for the receive path.
   assumes: design, checker and link sink model compiled before it. */
`timescale 1ns/1ps
module ddc_nco_decimator_bench;
    reg ref_clk, rst_n, clk_en, sysref, reg_wr, reg_rd, zero_mode, rd_pend;
    reg [4:0] adc_data, dc_code;
    reg [9:0] reg_addr;
    reg [7:0] reg_wdata;
    reg [15:0] w;
    reg [31:0] c0;
    wire [7:0] reg_rdata;
    wire init_done, iq_vld, smp_vld;
    wire signed [15:0] iq_i, iq_q, smp_i, smp_q;
    wire [31:0] smp_count;
    integer fail_count, compares, n, k;
    integer fa_t[4] = '{3200, 3200, 3200, 3072};
    integer fi_t[4] = '{140, 180, 180, 250};
    integer sel_t[4] = '{3, 4, 1, 2};
    integer fac_t[4] = '{16, 12, 32, 24};
    reg [7:0] rq[$];
    reg [31:0] iq_exp[$];
    ddc_nco_decimator #(.OW(16)) ddc_nco_decimator_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .adc_data(adc_data), .sysref(sysref), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .init_done(init_done), .iq_vld(iq_vld),
        .iq_i(iq_i), .iq_q(iq_q));
    iq_link_sink #(.OW(16)) iq_link_sink_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .iq_vld(iq_vld),
        .iq_i(iq_i), .iq_q(iq_q), .smp_vld(smp_vld), .smp_i(smp_i), .smp_q(smp_q), .smp_count(smp_count));
    // ----
    // tasks
    // ----
    task summarize;
        begin
            if (fail_count == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task check(input string name, input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [9:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [9:0] a, input [7:0] e);
        begin
            @(posedge ref_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            rq.push_back(e);
            @(posedge ref_clk);
            reg_rd <= 1'b0;
        end
    endtask
    task wait_init;
        begin
            n = 0;
            repeat (2) @(negedge ref_clk);
            while (init_done !== 1'b1 && n < 200) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            if (n >= 200) begin
                fail_count = fail_count + 1;
                summarize;
            end
        end
    endtask
    // sysref restart, let the chain settle, then expect six {i, q} samples
    task dc_check(input [31:0] e);
        begin
            @(posedge ref_clk);
            sysref <= 1'b1;
            repeat (8) @(posedge ref_clk);
            sysref <= 1'b0;
            repeat (1500) @(posedge ref_clk);
            repeat (6) iq_exp.push_back(e);
            n = 0;
            while (iq_exp.size() > 0 && n < 400) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            if (n >= 400) begin
                fail_count = fail_count + 1;
                summarize;
            end
        end
    endtask
    // tuning words worked out from the clock rate, if and select
    function [15:0] words(input integer fa, input integer fi, input integer sel);
        real r, x;
        integer c, m, f;
        begin
            r = fi * 1.0 / fa;
            c = $rtoi(64.0 * r + 0.5);
            m = (sel == 2 || sel == 4) ? 3072 : 4096;
            x = m * (r - c / 64.0);
            f = (x < 0.0) ? -$rtoi(0.5 - x) : $rtoi(x + 0.5);
            words = {c[7:0], f[7:0]};
        end
    endfunction
    // ----
    // clock, stimulus and monitor
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        adc_data <= zero_mode ? dc_code : 5'($urandom);
    always @(negedge ref_clk) begin
        if (rd_pend)
            check("reg_rdata", {8'h00, rq.pop_front()}, {8'h00, reg_rdata});
        rd_pend = reg_rd;
        if (smp_vld && iq_exp.size() > 0) begin
            check("iq_i", iq_exp[0][31:16], smp_i);
            check("iq_q", iq_exp[0][15:0], smp_q);
            void'(iq_exp.pop_front());
        end
    end
    initial begin
        fail_count = 0;
        compares = 0;
        {rst_n, sysref, reg_wr, reg_rd, zero_mode, rd_pend} = 6'h00;
        clk_en = 1'b1;
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        adc_data = 5'h10;
        dc_code = 5'h10;
        k = $urandom(41);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_init;
        w = words(3200, 200, 4);
        rd(10'h140, 8'h04);
        rd(10'h141, w[15:8]);
        rd(10'h142, w[7:0]);
        rd(10'h3ff, 8'h00);
        rd(10'h147, 8'h00);
        wr(10'h143, 8'h2a);
        wr(10'h144, 8'h55);
        wr(10'h145, 8'h03);
        rd(10'h143, 8'h2a);
        rd(10'h144, 8'h55);
        rd(10'h145, 8'h03);
        for (k = 0; k < 4; k = k + 1) begin
            wr(10'h140, 8'(sel_t[k]));
            wr(10'h100, 8'(fa_t[k]));
            wr(10'h101, 8'(fa_t[k] >> 8));
            wr(10'h102, 8'(fi_t[k]));
            wr(10'h103, 8'(fi_t[k] >> 8));
            wait_init;
            w = words(fa_t[k], fi_t[k], sel_t[k]);
            rd(10'h140, 8'(sel_t[k]));
            rd(10'h141, w[15:8]);
            rd(10'h142, w[7:0]);
            repeat (800) @(negedge ref_clk);
            c0 = smp_count;
            repeat (384) @(negedge ref_clk);
            check("out_count", 16'(384 / fac_t[k]), smp_count[15:0] - c0[15:0]);
        end
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        c0 = smp_count;
        w = iq_i;
        repeat (50) @(negedge ref_clk);
        check("frozen_count", c0[15:0], smp_count[15:0]);
        check("frozen_iq", w, iq_i);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        zero_mode <= 1'b1;
        dc_check(32'h0000_0000);
        wr(10'h141, 8'h00);
        wr(10'h142, 8'h00);
        wr(10'h143, 8'h00);
        wr(10'h144, 8'h00);
        wr(10'h145, 8'h00);
        // +8 lsb dc: 8*64/4 per sample, three per stage-one sum, unity dec2 gain
        dc_code <= 5'h18;
        dc_check(32'h0180_0000);
        wr(10'h143, 8'h20);
        dc_check(32'hfe80_0000);
        wr(10'h143, 8'h00);
        wr(10'h145, 8'h02);
        dc_check(32'hfe80_0000);
        summarize;
    end
endmodule // ddc_nco_decimator_bench
